// ### verilog/nvpw_top.sv
/*
  Nonvolatile memory partition and write-protect configuration block with
  identity words, reached over AXI4-Lite. Assumes the nonvolatile images are
  stable at reset release and all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`include "nvpw_defines.svh"
module nvpw_top
  import nvpw_pkg::*;
#(
  parameter logic [15:0] LAST_ADDR = 16'h3FFF,
  parameter logic [11:0] PART_ID = 12'h05A, // arbitrary value
  parameter logic [5:0] MAJOR_REV = 6'h01, // arbitrary value
  parameter logic [5:0] MINOR_REV = 6'h00 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // nonvolatile images and programming mode
  input wire logic [15:0] nvm_cfg4_image,
  input wire logic [15:0] nvm_cfg5_image,
  input wire logic lvp_programming_active,
  // partition controls
  output logic storage_area_write_lock_n,
  output logic eeprom_write_lock_n,
  output logic config_write_lock_n,
  output logic boot_region_write_lock_n,
  output logic application_write_lock_n,
  output logic storage_area_enable_n,
  output logic boot_region_enable_n,
  output logic low_voltage_programming_enable,
  output logic eeprom_readout_lock_n,
  output logic program_readout_lock_n,
  output logic [15:0] boot_region_end,
  output logic [15:0] program_exec_limit,
  // write checking
  output logic write_error_flag,
  output logic nvm_write_grant,
  output logic [15:0] nvm_write_addr,
  output logic config_loaded
);
  nvpw_reg_if regs ();
  nvpw_state_e st_q;
  logic [15:0] cfg4_q, cfg5_q, cfg4_req, cfg4_new, cfg5_new, chk_addr;
  logic [31:0] rdata_c;
  logic wr_cfg4, wr_cfg5, wr_cmd, wr_stat, wr_chk, erase_cmd, cfg_rej, chk_locked, running;
  nvpw_region_e chk_region;

  nvpw_axil_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs)
  );

  // write address to check comes from the low half of the data word
  assign chk_addr = regs.wdata[15:0];

  nvpw_region_check #(.LAST_ADDR(LAST_ADDR)) u_check (
    .addr(chk_addr),
    .cfg4(cfg4_q),
    .region(chk_region),
    .locked(chk_locked)
  );

  // indexes that software may both read and write
  function automatic logic nvpw_shared_idx_f(input logic [15:0] idx);
    nvpw_shared_idx_f = (idx == `NVPW_IDX_CFG4) || (idx == `NVPW_IDX_CFG5) || (idx == `NVPW_IDX_STAT) ||
      (idx == `NVPW_IDX_WCHK);
  endfunction : nvpw_shared_idx_f

  // write decode
  assign running = (st_q == NVPW_ST_RUN);
  assign wr_cfg4 = regs.wr & running & (regs.widx == `NVPW_IDX_CFG4);
  assign wr_cfg5 = regs.wr & running & (regs.widx == `NVPW_IDX_CFG5);
  assign wr_cmd = regs.wr & running & (regs.widx == `NVPW_IDX_CMD);
  assign wr_stat = regs.wr & running & (regs.widx == `NVPW_IDX_STAT);
  assign wr_chk = regs.wr & running & (regs.widx == `NVPW_IDX_WCHK) & (regs.wstrb[1:0] == 2'h3);
  assign erase_cmd = wr_cmd & regs.wstrb[0] & regs.wdata[`NVPW_B_ERASE];
  // writes add the command index, reads the identity and map words; each side decodes its own index
  assign regs.whit = nvpw_shared_idx_f(regs.widx) || (regs.widx == `NVPW_IDX_CMD);
  assign regs.rhit = nvpw_shared_idx_f(regs.ridx) || (regs.ridx == `NVPW_IDX_REV) ||
    (regs.ridx == `NVPW_IDX_PART) || (regs.ridx == `NVPW_IDX_MAP);

  assign cfg_rej = (wr_cfg4 | wr_cfg5) & ~cfg4_q[`NVPW_B_CFWL];

  // next partition word from a software write
  always_comb
  begin
    cfg4_req = nvpw_merge16_f(cfg4_q, regs.wdata[15:0], regs.wstrb[1:0]) & `NVPW_CFG4_RST;
    cfg4_new = (cfg4_req & ~`NVPW_CFG4_STICKY) | (cfg4_req & cfg4_q & `NVPW_CFG4_STICKY);
    if (!cfg4_q[`NVPW_B_BREN])
      cfg4_new[`NVPW_BSZ_HI:`NVPW_BSZ_LO] = cfg4_q[`NVPW_BSZ_HI:`NVPW_BSZ_LO];
    if (lvp_programming_active && !cfg4_req[`NVPW_B_LVP])
      cfg4_new[`NVPW_B_LVP] = cfg4_q[`NVPW_B_LVP];
  end

  assign cfg5_new = cfg5_q & nvpw_merge16_f(cfg5_q, regs.wdata[15:0], regs.wstrb[1:0]) & `NVPW_CFG5_RST;

  // load-then-run sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_q <= NVPW_ST_LOAD;
    else
    begin
      case (st_q)
        NVPW_ST_LOAD: st_q <= NVPW_ST_RUN;
        NVPW_ST_RUN: st_q <= NVPW_ST_RUN;
        default: st_q <= NVPW_ST_LOAD;
      endcase
    end
  end

  // configuration words: load, erase, guarded writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg4_q <= `NVPW_CFG4_RST;
      cfg5_q <= `NVPW_CFG5_RST;
    end
    else if (st_q == NVPW_ST_LOAD)
    begin
      cfg4_q <= nvm_cfg4_image & `NVPW_CFG4_RST;
      cfg5_q <= nvm_cfg5_image & `NVPW_CFG5_RST;
    end
    else if (erase_cmd)
    begin
      cfg4_q <= `NVPW_CFG4_RST;
      cfg5_q <= `NVPW_CFG5_RST;
    end
    else if (!cfg_rej)
    begin
      if (wr_cfg4)
        cfg4_q <= cfg4_new;
      // read-out locks take effect at once
      if (wr_cfg5)
        cfg5_q <= cfg5_new;
    end
  end

  // sticky error, set wins over clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      write_error_flag <= 1'b0;
    else if (cfg_rej | (wr_chk & chk_locked))
      write_error_flag <= 1'b1;
    else if (wr_stat & regs.wstrb[0] & regs.wdata[`NVPW_B_WERR])
      write_error_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nvm_write_grant <= 1'b0;
      nvm_write_addr <= 16'h0000;
    end
    else
    begin
      nvm_write_grant <= wr_chk & ~chk_locked;
      if (wr_chk)
        nvm_write_addr <= chk_addr;
    end
  end

  // decoded partition map
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      boot_region_end <= 16'h0000;
      program_exec_limit <= LAST_ADDR;
      config_loaded <= 1'b0;
    end
    else
    begin
      boot_region_end <= cfg4_q[`NVPW_B_BREN] ? 16'h0000 :
        nvpw_boot_end_f(cfg4_q[`NVPW_BSZ_HI:`NVPW_BSZ_LO], LAST_ADDR);
      program_exec_limit <= cfg4_q[`NVPW_B_SAEN] ? LAST_ADDR : LAST_ADDR - `NVPW_SAF_WORDS;
      config_loaded <= running;
    end
  end

  assign storage_area_write_lock_n = cfg4_q[`NVPW_B_SAWL];
  assign eeprom_write_lock_n = cfg4_q[`NVPW_B_EEWL];
  assign config_write_lock_n = cfg4_q[`NVPW_B_CFWL];
  assign boot_region_write_lock_n = cfg4_q[`NVPW_B_BRWL];
  assign application_write_lock_n = cfg4_q[`NVPW_B_APWL];
  assign storage_area_enable_n = cfg4_q[`NVPW_B_SAEN];
  assign boot_region_enable_n = cfg4_q[`NVPW_B_BREN];
  assign low_voltage_programming_enable = cfg4_q[`NVPW_B_LVP];
  assign eeprom_readout_lock_n = cfg5_q[`NVPW_B_EERD];
  assign program_readout_lock_n = cfg5_q[`NVPW_B_PFRD];

  // read data mux
  always_comb
  begin
    case (regs.ridx)
      `NVPW_IDX_REV: rdata_c = {16'h0000, 2'h0, `NVPW_REV_FIXED, MAJOR_REV, MINOR_REV};
      `NVPW_IDX_PART: rdata_c = {16'h0000, 2'h0, `NVPW_PART_FIXED, PART_ID};
      `NVPW_IDX_CFG4: rdata_c = {16'h0000, cfg4_q};
      `NVPW_IDX_CFG5: rdata_c = {16'h0000, cfg5_q};
      `NVPW_IDX_STAT: rdata_c = {30'h00000000, config_loaded, write_error_flag};
      `NVPW_IDX_WCHK: rdata_c = {16'h0000, nvm_write_addr};
      `NVPW_IDX_MAP: rdata_c = {program_exec_limit, boot_region_end};
      default: rdata_c = 32'h00000000;
    endcase
  end
  assign regs.rdata = rdata_c;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_locks_only_clear: assert property (running && !erase_cmd |=>
    ((cfg4_q & ~$past(cfg4_q)) & `NVPW_CFG4_STICKY) == 16'h0000)
    else $error("a cleared lock bit was set without erase");
  chk_readout_sticky: assert property (running && !erase_cmd |=>
    ((cfg5_q & ~$past(cfg5_q)) & `NVPW_CFG5_RST) == 16'h0000)
    else $error("read-out protection removed without erase");
  chk_erase_restores: assert property (erase_cmd |=>
    cfg4_q == `NVPW_CFG4_RST && cfg5_q == `NVPW_CFG5_RST && storage_area_enable_n ##1 boot_region_end == 16'h0000)
    else $error("bulk erase did not restore erased values");
  chk_size_frozen: assert property (running && !cfg4_q[`NVPW_B_BREN] && !erase_cmd |=>
    $stable(cfg4_q[`NVPW_BSZ_HI:`NVPW_BSZ_LO]))
    else $error("boot size changed while boot block enabled");
  chk_lvp_kept: assert property (running && lvp_programming_active && cfg4_q[`NVPW_B_LVP] && !erase_cmd |=>
    low_voltage_programming_enable)
    else $error("programming enable dropped during programming");
  chk_cfg_locked: assert property ((wr_cfg4 || wr_cfg5) && !config_write_lock_n |=>
    $stable(cfg4_q) && $stable(cfg5_q) && write_error_flag)
    else $error("locked configuration word changed");
  chk_boot_cap: assert property (boot_region_end <= (LAST_ADDR >> 1))
    else $error("boot end beyond half of flash");
  chk_boot_decode: assert property (!cfg4_q[`NVPW_B_BREN] && cfg4_q[2:0] == 3'b110 |=>
    boot_region_end == 16'h03FF)
    else $error("boot size code decoded wrongly");
  chk_locked_reject: assert property (wr_chk && chk_locked |=>
    write_error_flag && !nvm_write_grant)
    else $error("locked write not refused");
  chk_saf_limit: assert property (running && !storage_area_enable_n |=>
    program_exec_limit == LAST_ADDR - 16'h0080)
    else $error("storage area still executable");

  // read path, grant origin, flag clear, disabled boot and immediate read-out locks
  chk_rev_fixed: assert property (regs.rd && regs.ridx == `NVPW_IDX_REV |=>
    s_axi_rdata[13:12] == `NVPW_REV_FIXED)
    else $error("revision reserved bits wrong");
  chk_part_fixed: assert property (regs.rd && regs.ridx == `NVPW_IDX_PART |=>
    s_axi_rdata[13:12] == `NVPW_PART_FIXED && s_axi_rdata[11:0] == PART_ID)
    else $error("part word reads wrongly");
  chk_grant_unlocked: assert property (nvm_write_grant |->
    $past(wr_chk) && !$past(chk_locked))
    else $error("write granted without an unlocked check");
  chk_error_clear: assert property (wr_stat && regs.wstrb[0] && regs.wdata[`NVPW_B_WERR] |=>
    !write_error_flag)
    else $error("write error flag not cleared");
  chk_boot_disabled: assert property (running && boot_region_enable_n |=>
    boot_region_end == 16'h0000)
    else $error("boot end set while boot block disabled");
  chk_readout_now: assert property (wr_cfg5 && config_write_lock_n && regs.wstrb[0] &&
    !regs.wdata[`NVPW_B_PFRD] |=> !program_readout_lock_n)
    else $error("read-out lock not applied at once");

  cov_erase: cover property (erase_cmd ##1 config_loaded);
  cov_reject: cover property (wr_chk && chk_locked && chk_region == NVPW_RGN_BOOT);
  cov_grant: cover property (wr_chk && !chk_locked ##1 nvm_write_grant);
  cov_cfg_lock: cover property (wr_cfg4 && !regs.wdata[`NVPW_B_CFWL] ##1 !config_write_lock_n);
  cov_lvp_hold: cover property (wr_cfg4 && lvp_programming_active && !regs.wdata[`NVPW_B_LVP]);
endmodule : nvpw_top

// ### verilog/nvpw_defines.svh
/*
  Offsets, bit positions, reset values and fixed codes of the partition and
  write-protect block. Assumes nothing; definitions only.
*/
`ifndef NVPW_DEFINES_SVH
`define NVPW_DEFINES_SVH
// register indexes; byte address is four times the index
`define NVPW_IDX_REV 16'h8005
`define NVPW_IDX_PART 16'h8006
`define NVPW_IDX_CFG4 16'h800A
`define NVPW_IDX_CFG5 16'h800B
`define NVPW_IDX_CMD 16'h8010
`define NVPW_IDX_STAT 16'h8011
`define NVPW_IDX_WCHK 16'h8012
`define NVPW_IDX_MAP 16'h8013
// partition word bit positions
`define NVPW_B_LVP 13
`define NVPW_B_SAWL 11
`define NVPW_B_EEWL 10
`define NVPW_B_CFWL 9
`define NVPW_B_BRWL 8
`define NVPW_B_APWL 7
`define NVPW_B_SAEN 4
`define NVPW_B_BREN 3
`define NVPW_BSZ_HI 2
`define NVPW_BSZ_LO 0
// read-out lock word bit positions
`define NVPW_B_EERD 1
`define NVPW_B_PFRD 0
// command and status bits
`define NVPW_B_ERASE 0
`define NVPW_B_WERR 0
`define NVPW_B_LOADED 1
// reset (erased) values and masks
`define NVPW_CFG4_RST 16'h2F9F
`define NVPW_CFG5_RST 16'h0003
`define NVPW_CFG4_STICKY 16'h0F98
// fixed bits 13:12 of the identity words
`define NVPW_PART_FIXED 2'h3
`define NVPW_REV_FIXED 2'h2
// address map of the nonvolatile space
`define NVPW_SAF_WORDS 16'h0080
`define NVPW_EE_FIRST 16'hF000
`define NVPW_EE_LAST 16'hF0FF
`define NVPW_CFGA_FIRST 16'h8007
`define NVPW_CFGA_LAST 16'h800B
// bus responses
`define NVPW_RESP_OKAY 2'h0
`define NVPW_RESP_SLVERR 2'h2
`endif

// ### verilog/nvpw_pkg.sv
/*
  Types and shared decode functions of the partition and write-protect block.
  Assumes the defines header is on the include path.
*/
package nvpw_pkg;
  typedef enum logic [2:0] {NVPW_RGN_APP = 3'b000, NVPW_RGN_BOOT = 3'b001, NVPW_RGN_SAF = 3'b010,
    NVPW_RGN_EE = 3'b011, NVPW_RGN_CFG = 3'b100, NVPW_RGN_NONE = 3'b101} nvpw_region_e;
  typedef enum logic [0:0] {NVPW_ST_LOAD = 1'b0, NVPW_ST_RUN = 1'b1} nvpw_state_e;

  // boot block end address from the size code, never past half the flash
  function automatic logic [15:0] nvpw_boot_end_f(input logic [2:0] code, input logic [15:0] last_addr);
    logic [15:0] raw;
    logic [15:0] half;
    half = last_addr >> 1;
    case (code)
      3'b111: raw = 16'h01FF;
      3'b110: raw = 16'h03FF;
      3'b101: raw = 16'h07FF;
      3'b100: raw = 16'h0FFF;
      3'b011: raw = 16'h1FFF;
      default: raw = 16'h3FFF;
    endcase
    nvpw_boot_end_f = (raw > half) ? half : raw;
  endfunction : nvpw_boot_end_f

  // byte-lane merge of a 16-bit word
  function automatic logic [15:0] nvpw_merge16_f(input logic [15:0] old, input logic [15:0] nw,
    input logic [1:0] strb);
    nvpw_merge16_f = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : nvpw_merge16_f
endpackage : nvpw_pkg

// ### verilog/nvpw_reg_if.sv
/*
  Register request carrier between the bus slave and the protection core.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface nvpw_reg_if;
  logic wr;
  logic [15:0] widx;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic whit;
  logic rd;
  logic [15:0] ridx;
  logic rhit;
  logic [31:0] rdata;
  modport bus_side (output wr, widx, wdata, wstrb, rd, ridx, input whit, rhit, rdata);
  modport core_side (input wr, widx, wdata, wstrb, rd, ridx, output whit, rhit, rdata);
endinterface : nvpw_reg_if

// ### verilog/nvpw_region_check.sv
/*
  Classifies a nonvolatile word address into its partition and reports
  whether that partition is write-locked. Assumes the partition word is current.
*/
`timescale 1ns/1ps
`include "nvpw_defines.svh"
module nvpw_region_check
  import nvpw_pkg::*;
#(
  parameter logic [15:0] LAST_ADDR = 16'h3FFF
) (
  // query
  input wire logic [15:0] addr,
  input wire logic [15:0] cfg4,
  // answer
  output nvpw_region_e region,
  output logic locked
);
  // partition lookup and lock selection
  always_comb
  begin
    region = NVPW_RGN_NONE;
    locked = 1'b1;
    if (addr >= `NVPW_EE_FIRST && addr <= `NVPW_EE_LAST)
    begin
      region = NVPW_RGN_EE;
      locked = ~cfg4[`NVPW_B_EEWL];
    end
    else if (addr >= `NVPW_CFGA_FIRST && addr <= `NVPW_CFGA_LAST)
    begin
      region = NVPW_RGN_CFG;
      locked = ~cfg4[`NVPW_B_CFWL];
    end
    else if (addr <= LAST_ADDR)
    begin
      if (!cfg4[`NVPW_B_BREN] && addr <= nvpw_boot_end_f(cfg4[`NVPW_BSZ_HI:`NVPW_BSZ_LO], LAST_ADDR))
      begin
        region = NVPW_RGN_BOOT;
        locked = ~cfg4[`NVPW_B_BRWL];
      end
      else if (!cfg4[`NVPW_B_SAEN] && addr > LAST_ADDR - `NVPW_SAF_WORDS)
      begin
        region = NVPW_RGN_SAF;
        locked = ~cfg4[`NVPW_B_SAWL];
      end
      else
      begin
        region = NVPW_RGN_APP;
        locked = ~cfg4[`NVPW_B_APWL];
      end
    end
  end
endmodule : nvpw_region_check

// ### verilog/nvpw_axil_slave.sv
/*
  AXI4-Lite slave front end: takes one write and one read at a time and
  hands them to the core as one-cycle pulses. Assumes the core answers hit
  and read data combinationally in the pulse cycle.
*/
`timescale 1ns/1ps
`include "nvpw_defines.svh"
module nvpw_axil_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  nvpw_reg_if.bus_side regs
);
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, ar_have_q, ar_have_d;
  logic bvalid_d, rvalid_d, do_wr, do_rd, waddr_ok, raddr_ok;
  logic [31:0] waddr_q, raddr_q, wdata_q;
  logic [3:0] wstrb_q;

  // channel bookkeeping
  always_comb
  begin
    aw_have_d = aw_have_q | (s_axi_awvalid & s_axi_awready);
    w_have_d = w_have_q | (s_axi_wvalid & s_axi_wready);
    ar_have_d = ar_have_q | (s_axi_arvalid & s_axi_arready);
    do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
    do_rd = ar_have_q & ~s_axi_rvalid;
    if (do_wr)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
    end
    if (do_rd)
      ar_have_d = 1'b0;
    bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
    rvalid_d = do_rd | (s_axi_rvalid & ~s_axi_rready);
  end

  // only aligned words inside the 18-bit window decode
  assign waddr_ok = (waddr_q[31:18] == 14'h0000) && (waddr_q[1:0] == 2'h0);
  assign raddr_ok = (raddr_q[31:18] == 14'h0000) && (raddr_q[1:0] == 2'h0);
  assign regs.wr = do_wr & waddr_ok;
  assign regs.widx = waddr_q[17:2];
  assign regs.wdata = wdata_q;
  assign regs.wstrb = wstrb_q;
  assign regs.rd = do_rd & raddr_ok;
  assign regs.ridx = raddr_q[17:2];

  // handshake flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      ar_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      ar_have_q <= ar_have_d;
      s_axi_awready <= ~aw_have_d & ~bvalid_d;
      s_axi_wready <= ~w_have_d & ~bvalid_d;
      s_axi_arready <= ~ar_have_d & ~rvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_rvalid <= rvalid_d;
    end
  end

  // payload capture and answers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      waddr_q <= 32'h00000000;
      raddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bresp <= `NVPW_RESP_OKAY;
      s_axi_rresp <= `NVPW_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
        waddr_q <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_arvalid & s_axi_arready)
        raddr_q <= s_axi_araddr;
      if (do_wr)
        s_axi_bresp <= (waddr_ok & regs.whit) ? `NVPW_RESP_OKAY : `NVPW_RESP_SLVERR;
      if (do_rd)
      begin
        s_axi_rresp <= (raddr_ok & regs.rhit) ? `NVPW_RESP_OKAY : `NVPW_RESP_SLVERR;
        s_axi_rdata <= (raddr_ok & regs.rhit) ? regs.rdata : 32'h00000000;
      end
    end
  end
endmodule : nvpw_axil_slave

// ### verification/nvpw_prog_model.sv
/*
  Programmer side: erased nonvolatile images and the low-voltage programming mode.
  Assumes the bench changes its request just after a clk edge.
*/
`timescale 1ns/1ps
module nvpw_prog_model (
  // request from the bench
  input wire logic clk,
  input wire logic lvp_req,
  // device side
  output logic [15:0] cfg4_image,
  output logic [15:0] cfg5_image,
  output logic lvp_active
);
  logic lvp_q = 1'b0;
  // erased part; unused bits high so the device has to mask them
  assign cfg4_image = 16'hFFFF;
  assign cfg5_image = 16'hFFFF;
  // programming mode follows the request one edge later
  always @(posedge clk) lvp_q <= lvp_req;
  assign lvp_active = lvp_q;
endmodule : nvpw_prog_model

// ### verification/tb.sv
/*
  Bench for the partition and write-protect block: AXI4-Lite master, a model of both words, random write checks.
  Assumes the programmer model beside it and the design's own assertions.
*/
`timescale 1ns/1ps
`include "nvpw_defines.svh"
module tb;
  logic clk = 0, rst_n = 0, lvp_req = 0, ah, wh, dh;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd, lfsr = 96673;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, grant, err, loaded, lvp_act;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] img4, img5, bend, xlim, waddr;
  logic [9:0] outs;
  int mismatches = 0, num_checks = 0, grants = 0, exp_grants = 0, m4 = 32'h2F9F, m5 = 3;
  int exp_q[$];
  // 50 MHz clock
  always #10 clk = ~clk;
  // count grant pulses and match each to the oldest allowed address
  always @(posedge clk)
    if (grant === 1'b1)
    begin
      grants <= grants + 1;
      check("granted address", (exp_q.size() > 0) ? exp_q.pop_front() : -1, waddr);
    end
  nvpw_prog_model i_nvpw_prog_model (.clk, .lvp_req, .cfg4_image(img4), .cfg5_image(img5), .lvp_active(lvp_act));
  // identity values are arbitrary
  nvpw_top #(.PART_ID(12'h3C5), .MAJOR_REV(6'h2A), .MINOR_REV(6'h15)) i_nvpw_top (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nvm_cfg4_image(img4), .nvm_cfg5_image(img5),
    .lvp_programming_active(lvp_act), .storage_area_write_lock_n(outs[9]), .eeprom_write_lock_n(outs[8]),
    .config_write_lock_n(outs[7]), .boot_region_write_lock_n(outs[6]), .application_write_lock_n(outs[5]),
    .storage_area_enable_n(outs[4]), .boot_region_enable_n(outs[3]), .low_voltage_programming_enable(outs[2]),
    .eeprom_readout_lock_n(outs[1]), .program_readout_lock_n(outs[0]), .boot_region_end(bend),
    .program_exec_limit(xlim), .write_error_flag(err), .nvm_write_grant(grant), .nvm_write_addr(waddr),
    .config_loaded(loaded));

  // compare and count
  task automatic check(input string what, input logic [31:0] want, input logic [31:0] got);
    num_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, want, got);
    end
  endtask : check

  // one write (wr high) or read; each valid drops after its own handshake
  task automatic xfer(input bit wr, input logic [15:0] idx, input logic [31:0] d);
    int n = 0;
    dh = 0;
    @(posedge clk);
    if (wr)
    begin
      s_axi_awaddr <= {14'h0, idx, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= {14'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!dh && n++ < 40)
    begin
      @(negedge clk);
      ah = wr ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      wh = s_axi_wvalid & s_axi_wready;
      dh = wr ? s_axi_bvalid : s_axi_rvalid;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk);
      if (ah && wr) s_axi_awvalid <= 1'b0;
      if (ah && !wr) s_axi_arvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    check("bus answer", 1, dh);
  endtask : xfer

  // model boot end, capped at half the flash
  function automatic int bend_m();
    int raw = (1 << (16 - m4[2:0])) - 1;
    return m4[3] ? 0 : (raw > 16'h3FFF / 2 ? 16'h3FFF / 2 : raw);
  endfunction : bend_m

  // model write check
  function automatic int allowed(input int a);
    if (a >= 16'hF000 && a <= 16'hF0FF) return m4[10];
    if (a >= 16'h8007 && a <= 16'h800B) return m4[9];
    if (a > 16'h3FFF) return 0;
    if (!m4[3] && a <= bend_m()) return m4[8];
    if (!m4[4] && a > 16'h3F7F) return m4[11];
    return m4[7];
  endfunction : allowed

  // compare control outputs and both words with the model
  task automatic outchk();
    repeat (3) @(negedge clk);
    check("controls", {m4[11:7], m4[4:3], m4[13], m5[1:0]}, outs);
    check("boot end", bend_m(), bend);
    check("exec limit", m4[4] ? 16'h3FFF : 16'h3FFF - 16'd128, xlim);
    xfer(0, `NVPW_IDX_CFG4, 0);
    check("partition word", m4, rd);
    xfer(0, `NVPW_IDX_CFG5, 0);
    check("readout word", m5, rd);
  endtask : outchk

  // partition word write mirrored in the model
  task automatic w4(input logic [15:0] d);
    xfer(1, `NVPW_IDX_CFG4, {16'h0, d});
    if (m4[9])
      m4 = (m4 & d & 32'h0F98) | (((lvp_act && !d[13]) ? m4 : d) & 32'h2000) | ((m4[3] ? d : m4) & 32'h7);
    outchk();
  endtask : w4

  // bulk erase
  task automatic erase();
    xfer(1, `NVPW_IDX_CMD, 1);
    m4 = 32'h2F9F;
    m5 = 3;
    outchk();
  endtask : erase

  // next value of the stimulus register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // random target address through the write check
  task automatic wchk();
    logic [15:0] a;
    lfsr = lfsr_next(lfsr);
    case (lfsr[17:16])
      2'd0: a = {2'b0, lfsr[13:0]};
      2'd1: a = {8'hF0, lfsr[7:0]};
      2'd2: a = 16'h8007 + lfsr[1:0];
      default: a = lfsr[15:0];
    endcase
    xfer(1, `NVPW_IDX_STAT, 1);
    if (allowed(a) != 0)
      exp_q.push_back(a);
    xfer(1, `NVPW_IDX_WCHK, {16'h0, a});
    exp_grants += allowed(a);
    repeat (3) @(negedge clk);
    check("error flag", !allowed(a), err);
    check("grant count", exp_grants, grants);
    check("checked address", a, waddr);
    check("pending grants", 0, exp_q.size());
  endtask : wchk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check("loaded", 1, loaded);
    outchk();
    xfer(0, `NVPW_IDX_REV, 0);
    check("revision", {18'h0, 2'b10, 6'h2A, 6'h15}, rd);
    xfer(0, `NVPW_IDX_PART, 0);
    check("part", {18'h0, 2'b11, 12'h3C5}, rd);
    xfer(1, `NVPW_IDX_PART, 0);
    check("part write", `NVPW_RESP_SLVERR, rs);
    xfer(0, 16'h0100, 0);
    check("unmapped", `NVPW_RESP_SLVERR, rs);
    for (int c = 0; c < 8; c++)
    begin
      erase();
      w4(((lfsr[15:0] | 16'h2200) & 16'h2F90) | c[2:0]);
      w4({13'h1FFF, c[2:0] ^ 3'h1});
      repeat (6) wchk();
    end
    xfer(1, `NVPW_IDX_STAT, 1);
    w4(16'h2D9F);
    w4(16'h0000);
    check("locked word write", 1, err);
    erase();
    for (int i = 0; i < 3; i++)
    begin
      xfer(1, `NVPW_IDX_CFG5, (i == 1) ? 3 : 2 - i);
      m5 = m5 & ((i == 1) ? 3 : 2 - i);
      outchk();
    end
    erase();
    @(posedge clk);
    lvp_req <= 1'b1;
    w4(16'h0F9F);
    @(posedge clk);
    lvp_req <= 1'b0;
    w4(16'h0F9F);
    erase();
    complete_run();
  end

  // cut a hang short
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : tb
